// ==== hbi_ctrl_pkg.sv ====
// constants for the host interface control register bank
package hbi_ctrl_pkg;
  // core-side word addresses
  localparam logic [15:0] ADDR_RTC_AND_HOST_STATUS_CTRL = 16'hf900;
  localparam logic [15:0] ADDR_HOST_RESET_AND_CFG_CTRL = 16'hf902;
  localparam logic [15:0] ADDR_RTC_INDEX_WINDOW = 16'hf904;
  localparam logic [15:0] ADDR_RTC_DATA_WINDOW = 16'hf906;
  localparam logic [15:0] ADDR_PNP_BASE_ADDRESS_LOW = 16'hf908;
  localparam logic [15:0] ADDR_PNP_BASE_ADDRESS_HIGH = 16'hf90a;
  localparam logic [15:0] ADDR_HOST_IRQ_ENABLE_CTRL = 16'hfea0;
  localparam logic [15:0] ADDR_HOST_IRQ_MODE_CTRL = 16'hfea2;
  localparam logic [15:0] ADDR_KEYBOARD_DATA_OUT = 16'hfea6;
  localparam logic [15:0] ADDR_MOUSE_DATA_OUT = 16'hfea8;
  localparam logic [15:0] ADDR_PM_DATA_OUT = 16'hfeae;
  // status/ctrl 1 fields
  localparam int LOCK_BIT = 0;
  localparam int LOCK_RST_BIT = 1;
  localparam int VIOL_BIT = 2;
  localparam int PWR_BIT = 3;
  localparam int MRST_BIT = 4;
  // status/ctrl 2 fields
  localparam int HRST_BIT = 0;
  localparam int VALID_BIT = 1;
  localparam int CFGLK_BIT = 2;
  localparam int POFF_BIT = 3;
  // irq enable fields
  localparam int KBD_HIE_BIT = 0;
  localparam int MOU_HIE_BIT = 1;
  localparam int OBE_CIE_BIT = 2;
  localparam int IBF_CIE_BIT = 3;
  localparam int PM_HIE_BIT = 4;
  localparam int PM_OBE_CIE_BIT = 5;
  localparam int PM_IBF_CIE_BIT = 6;
  localparam logic [7:0] IRQ_EN_MASK = 8'h7f;
  // irq mode fields
  localparam int MODE_LSB = 3;
  localparam int INV_BIT = 6;
  localparam logic [7:0] IRQ_MODE_RESET = 8'h07;
  localparam logic [7:0] IRQ_MODE_MASK = 8'h7f;
  // lock reset pulse length in clock cycles
  localparam logic [1:0] LOCK_RST_CYCLES = 2'h2;
  localparam logic [4:0] PULSE_MAX = 5'h10;
endpackage

// ==== irq_pulse_gen.sv ====
// one host irq line: manual, level or pulse signalling
`timescale 1ns/1ps
module irq_pulse_gen (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic hw_enable, // hardware generation selected
  input wire logic manual_level, // firmware level when hardware off
  input wire logic [2:0] mode, // 0 level, 1..5 pulse width code
  input wire logic invert, // invert hardware output
  input wire logic trigger, // data-out register written
  input wire logic output_buffer_full, // output buffer full flag
  output logic irq_out // line level
);
  logic [4:0] cnt_r;
  logic [4:0] width;
  logic active;

  always_comb begin
    case (mode)
      3'h1: width = 5'h01;
      3'h2: width = 5'h02;
      3'h3: width = 5'h04;
      3'h4: width = 5'h08;
      3'h5: width = hbi_ctrl_pkg::PULSE_MAX;
      default: width = 5'h00; // level or reserved: no pulse
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (hw_enable && trigger && width != 5'h00) begin
      cnt_r <= width;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // pulse mode idles high and dips low when not inverted
  assign active = (mode == 3'h0) ? output_buffer_full : (cnt_r == 5'h00);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else if (!hw_enable) begin
      irq_out <= manual_level;
    end else begin
      irq_out <= active ^ invert;
    end
  end
endmodule

// ==== host_interface_control_regs.sv ====
// core-side control and status registers of the host bus interface
`timescale 1ns/1ps
// Functional notes
// - on host/core rtc contention the later waits; host stalled by dropping channel ready
// - lock bit set gives the core the rtc windows; clear gives the host
// - writing 1 to lock reset sends a pulse to the rtc lock register, self-clears
// - host rtc access while locked sets violation flag; write 1 clears
// - bits 3 and 4 show live power-good and master-reset pins, read only
// - any reset clears bits 0,1,2; lock bit clears on warm and cold resets alike
// - host reset bit 1 holds reset output low; 0 releases unless extended
// - writing high address byte sets valid; write 1 clears; 0 ignored
// - base address captured at first plug-and-play write, later changes ignored
// - valid clear excludes stored address from comparison
// - address lock once set is sticky; blocks valid and address writes
// - power-off event routed to wake-up and interrupt units only when enabled
// - core rtc windows reach rtc index and data registers
// - address bytes survive warm reset
// - reset clears all non-reserved irq enable bits
// - keyboard irq manual when disabled, data-out write driven when enabled
// - mouse irq manual when disabled, data-out write driven when enabled
// - pm irq manual when disabled, data-out write driven when enabled
// - enabled out-empty core irq high while output buffer full clear
// - enabled in-full core irq high while input buffer full set
// - mode 0 level, codes 1..5 pulse 1,2,4,8,16 cycles
module host_interface_control_regs (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, any source, active low
  input wire logic cold_rst_n, // power-up or supervisory reset, active low
  input wire logic [15:0] core_addr, // core register address
  input wire logic core_wr, // core write strobe
  input wire logic core_rd, // core read strobe
  input wire logic [7:0] core_wdata, // core write data
  output logic [7:0] core_rdata, // core read data
  output logic core_wait, // core access stalled on rtc
  input wire logic host_power_good, // host power pin
  input wire logic host_warm_reset_pin, // host master reset pin
  input wire logic host_rtc_req, // host rtc cycle in progress
  output logic host_channel_ready, // low stretches host cycle
  output logic rtc_lock_reset_pulse, // resets rtc lock register
  output logic rtc_core_sel, // rtc port owned by core
  output logic rtc_core_wr_index, // core write of rtc index
  output logic rtc_core_wr_data, // core write of rtc data
  output logic rtc_core_rd_data, // core read of rtc data
  output logic [7:0] rtc_core_wdata, // data toward rtc
  input wire logic [7:0] rtc_index_rdata, // rtc index readback
  input wire logic [7:0] rtc_data_rdata, // rtc data readback
  input wire logic rtc_busy, // rtc transaction in progress
  input wire logic hw_reset_request, // other host reset source
  output logic host_reset_out_n, // host reset output, active low
  input wire logic pnp_first_write, // first plug-and-play write seen
  output logic [15:0] pnp_base_addr, // captured base address
  output logic pnp_addr_valid, // base address usable
  input wire logic power_off_event, // power-off event from rtc
  output logic power_off_to_units, // to wake-up and interrupt units
  input wire logic kbc_obf, // keyboard output buffer full
  input wire logic kbc_ibf, // keyboard input buffer full
  input wire logic pm_obf, // pm output buffer full
  input wire logic pm_ibf, // pm input buffer full
  output logic kbc_out_empty_irq, // core interrupt
  output logic kbc_in_full_irq, // core interrupt
  output logic pm_out_empty_irq, // core interrupt
  output logic pm_in_full_irq, // core interrupt
  output logic kbd_irq, // host irq1 level
  output logic mouse_irq, // host irq12 level
  output logic pm_irq // host irq11 level
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] pwr_s_r;
  logic [1:0] mrst_s_r;
  logic [1:0] hreq_s_r;
  logic [1:0] poff_s_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_s_r <= 2'h0;
      mrst_s_r <= 2'h0;
      hreq_s_r <= 2'h0;
      poff_s_r <= 2'h0;
    end else begin
      pwr_s_r <= {pwr_s_r[0], host_power_good};
      mrst_s_r <= {mrst_s_r[0], host_warm_reset_pin};
      hreq_s_r <= {hreq_s_r[0], host_rtc_req};
      poff_s_r <= {poff_s_r[0], power_off_event};
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic wr_st1, wr_st2, wr_idx, wr_dat, wr_bal, wr_bah, wr_ien, wr_mode;
  logic wr_kdo, wr_mdo, wr_pdo, rd_dat, rtc_acc;
  logic [7:0] st1_r, st2_r, ien_r, mode_r, bal_r, bah_r;
  logic lock_r, viol_r, hrst_r, valid_r, cfglk_r, poff_r;
  logic [1:0] lrst_cnt_r;
  logic host_owner_r;

  assign rtc_acc = hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_INDEX_WINDOW) ||
                   hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_DATA_WINDOW);
  // core rtc access waits while a host rtc cycle owns the rtc
  assign core_wait = rtc_acc && (core_wr || core_rd) && host_owner_r;

  assign wr_st1 = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_AND_HOST_STATUS_CTRL);
  assign wr_st2 = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_HOST_RESET_AND_CFG_CTRL);
  assign wr_bal = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_PNP_BASE_ADDRESS_LOW);
  assign wr_bah = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_PNP_BASE_ADDRESS_HIGH);
  assign wr_ien = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_HOST_IRQ_ENABLE_CTRL);
  assign wr_mode = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_HOST_IRQ_MODE_CTRL);
  assign wr_kdo = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_KEYBOARD_DATA_OUT);
  assign wr_mdo = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_MOUSE_DATA_OUT);
  assign wr_pdo = core_wr && hit(core_addr, hbi_ctrl_pkg::ADDR_PM_DATA_OUT);
  // rtc windows pass only when the core owns the rtc and no host cycle holds it
  assign wr_idx = core_wr && !core_wait && st1_r[hbi_ctrl_pkg::LOCK_BIT] &&
                  hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_INDEX_WINDOW);
  assign wr_dat = core_wr && !core_wait && st1_r[hbi_ctrl_pkg::LOCK_BIT] &&
                  hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_DATA_WINDOW);
  assign rd_dat = core_rd && !core_wait && st1_r[hbi_ctrl_pkg::LOCK_BIT] &&
                  hit(core_addr, hbi_ctrl_pkg::ADDR_RTC_DATA_WINDOW);

  assign rtc_core_sel = st1_r[hbi_ctrl_pkg::LOCK_BIT];
  assign rtc_core_wr_index = wr_idx;
  assign rtc_core_wr_data = wr_dat;
  assign rtc_core_rd_data = rd_dat;
  assign rtc_core_wdata = core_wdata;

  // ------------------------------------------------------------
  // rtc arbitration with the host
  // ------------------------------------------------------------
  // host gets the rtc on a fresh request only when the core is not mid-access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_owner_r <= 1'b0;
    end else if (!hreq_s_r[1]) begin
      host_owner_r <= 1'b0;
    end else if (!st1_r[hbi_ctrl_pkg::LOCK_BIT] && !rtc_busy) begin
      host_owner_r <= 1'b1;
    end
  end

  // a host cycle is stretched until it owns the rtc; a locked cycle stays ready
  assign host_channel_ready = !(hreq_s_r[1] && !host_owner_r &&
                                !st1_r[hbi_ctrl_pkg::LOCK_BIT]);

  // ------------------------------------------------------------
  // status and control 1
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (wr_st1) begin
      lock_r <= core_wdata[hbi_ctrl_pkg::LOCK_BIT];
    end
  end

  // lock reset pulse lasts a fixed count, then the bit drops by itself
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lrst_cnt_r <= 2'h0;
    end else if (wr_st1 && core_wdata[hbi_ctrl_pkg::LOCK_RST_BIT] && lrst_cnt_r == 2'h0) begin
      lrst_cnt_r <= hbi_ctrl_pkg::LOCK_RST_CYCLES;
    end else if (lrst_cnt_r != 2'h0) begin
      lrst_cnt_r <= lrst_cnt_r - 2'h1;
    end
  end
  assign rtc_lock_reset_pulse = (lrst_cnt_r != 2'h0);

  // set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      viol_r <= 1'b0;
    end else if (hreq_s_r[1] && lock_r) begin
      viol_r <= 1'b1;
    end else if (wr_st1 && core_wdata[hbi_ctrl_pkg::VIOL_BIT]) begin
      viol_r <= 1'b0;
    end
  end

  // pin bits are live synchronised levels, reserved bits zero
  assign st1_r = {3'h0, mrst_s_r[1], pwr_s_r[1], viol_r,
                  rtc_lock_reset_pulse, lock_r};

  // ------------------------------------------------------------
  // status and control 2
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrst_r <= 1'b0;
      poff_r <= 1'b0;
    end else if (wr_st2) begin
      hrst_r <= core_wdata[hbi_ctrl_pkg::HRST_BIT];
      poff_r <= core_wdata[hbi_ctrl_pkg::POFF_BIT];
    end
  end

  // high-byte write sets valid; a same-cycle clear loses to it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
    end else if (!cfglk_r) begin
      if (wr_bah) begin
        valid_r <= 1'b1;
      end else if (wr_st2 && core_wdata[hbi_ctrl_pkg::VALID_BIT]) begin
        valid_r <= 1'b0;
      end
    end
  end

  // lock survives warm reset; only the cold reset clears it
  always_ff @(posedge clk) begin
    if (!cold_rst_n) begin
      cfglk_r <= 1'b0;
    end else if (wr_st2 && core_wdata[hbi_ctrl_pkg::CFGLK_BIT]) begin
      cfglk_r <= 1'b1;
    end
  end
  assign st2_r = {4'h0, poff_r, cfglk_r, valid_r, hrst_r};

  assign host_reset_out_n = !(st2_r[hbi_ctrl_pkg::HRST_BIT] || hw_reset_request ||
                              !pwr_s_r[1]);
  assign power_off_to_units = poff_s_r[1] && st2_r[hbi_ctrl_pkg::POFF_BIT];

  // ------------------------------------------------------------
  // plug-and-play base address
  // ------------------------------------------------------------
  // no reset: contents kept over warm reset, undefined cold
  always_ff @(posedge clk) begin
    if (wr_bal && !st2_r[hbi_ctrl_pkg::CFGLK_BIT]) begin
      bal_r <= core_wdata;
    end
    if (wr_bah && !st2_r[hbi_ctrl_pkg::CFGLK_BIT]) begin
      bah_r <= core_wdata;
    end
  end

  logic captured_r;
  logic [15:0] pnp_base_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      captured_r <= 1'b0;
      pnp_base_r <= 16'h0000;
    end else if (pnp_first_write && !captured_r) begin
      captured_r <= 1'b1;
      pnp_base_r <= {bah_r, bal_r};
    end
  end
  assign pnp_base_addr = pnp_base_r;
  assign pnp_addr_valid = st2_r[hbi_ctrl_pkg::VALID_BIT];

  // ------------------------------------------------------------
  // irq enable and mode registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ien_r <= 8'h00;
    end else if (wr_ien) begin
      ien_r <= core_wdata & hbi_ctrl_pkg::IRQ_EN_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= hbi_ctrl_pkg::IRQ_MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= core_wdata & hbi_ctrl_pkg::IRQ_MODE_MASK;
    end
  end

  assign kbc_out_empty_irq = ien_r[hbi_ctrl_pkg::OBE_CIE_BIT] && !kbc_obf;
  assign kbc_in_full_irq = ien_r[hbi_ctrl_pkg::IBF_CIE_BIT] && kbc_ibf;
  assign pm_out_empty_irq = ien_r[hbi_ctrl_pkg::PM_OBE_CIE_BIT] && !pm_obf;
  assign pm_in_full_irq = ien_r[hbi_ctrl_pkg::PM_IBF_CIE_BIT] && pm_ibf;

  irq_pulse_gen u_kbd (
    .clk(clk), .rst_n(rst_n), .hw_enable(ien_r[hbi_ctrl_pkg::KBD_HIE_BIT]),
    .manual_level(mode_r[0]), .mode(mode_r[hbi_ctrl_pkg::MODE_LSB +: 3]),
    .invert(mode_r[hbi_ctrl_pkg::INV_BIT]), .trigger(wr_kdo), .output_buffer_full(kbc_obf),
    .irq_out(kbd_irq));
  irq_pulse_gen u_mouse (
    .clk(clk), .rst_n(rst_n), .hw_enable(ien_r[hbi_ctrl_pkg::MOU_HIE_BIT]),
    .manual_level(mode_r[1]), .mode(mode_r[hbi_ctrl_pkg::MODE_LSB +: 3]),
    .invert(mode_r[hbi_ctrl_pkg::INV_BIT]), .trigger(wr_mdo), .output_buffer_full(kbc_obf),
    .irq_out(mouse_irq));
  irq_pulse_gen u_pm (
    .clk(clk), .rst_n(rst_n), .hw_enable(ien_r[hbi_ctrl_pkg::PM_HIE_BIT]),
    .manual_level(mode_r[2]), .mode(mode_r[hbi_ctrl_pkg::MODE_LSB +: 3]),
    .invert(mode_r[hbi_ctrl_pkg::INV_BIT]), .trigger(wr_pdo), .output_buffer_full(pm_obf),
    .irq_out(pm_irq));

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    case (core_addr)
      hbi_ctrl_pkg::ADDR_RTC_AND_HOST_STATUS_CTRL: core_rdata = st1_r;
      hbi_ctrl_pkg::ADDR_HOST_RESET_AND_CFG_CTRL: core_rdata = st2_r;
      hbi_ctrl_pkg::ADDR_RTC_INDEX_WINDOW: core_rdata = rtc_index_rdata;
      hbi_ctrl_pkg::ADDR_RTC_DATA_WINDOW: core_rdata = rtc_data_rdata;
      hbi_ctrl_pkg::ADDR_PNP_BASE_ADDRESS_LOW: core_rdata = bal_r;
      hbi_ctrl_pkg::ADDR_PNP_BASE_ADDRESS_HIGH: core_rdata = bah_r;
      hbi_ctrl_pkg::ADDR_HOST_IRQ_ENABLE_CTRL: core_rdata = ien_r;
      hbi_ctrl_pkg::ADDR_HOST_IRQ_MODE_CTRL: core_rdata = {mode_r[7:3], pm_irq, mouse_irq, kbd_irq};
      default: core_rdata = 8'h00;
    endcase
  end
endmodule

// ==== hicr_chk.sv ====
// concurrent checks on the ports of the host interface control bank
`timescale 1ns/1ps
module hicr_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [15:0] core_addr, // address
  input wire logic core_wr, // write
  input wire logic core_rd, // read
  input wire logic [7:0] core_wdata, // write data
  input wire logic [7:0] core_rdata, // read data
  input wire logic core_wait, // stall
  input wire logic host_power_good, // pin
  input wire logic host_warm_reset_pin, // pin
  input wire logic rtc_lock_reset_pulse, // pulse
  input wire logic rtc_core_sel, // owner
  input wire logic rtc_core_wr_index, // index write
  input wire logic rtc_core_wr_data, // data write
  input wire logic [7:0] rtc_core_wdata, // rtc data
  input wire logic host_reset_out_n, // host reset
  input wire logic pnp_first_write, // capture
  input wire logic [15:0] pnp_base_addr, // base
  input wire logic pnp_addr_valid, // valid
  input wire logic power_off_event, // event
  input wire logic power_off_to_units, // routed
  input wire logic kbc_obf, // obf
  input wire logic kbc_ibf, // ibf
  input wire logic kbc_out_empty_irq, // irq
  input wire logic kbc_in_full_irq // irq
);
  localparam logic [15:0] A_CS1 = hbi_ctrl_pkg::ADDR_RTC_AND_HOST_STATUS_CTRL;
  localparam logic [15:0] A_CS2 = hbi_ctrl_pkg::ADDR_HOST_RESET_AND_CFG_CTRL;
  localparam logic [15:0] A_IDX = hbi_ctrl_pkg::ADDR_RTC_INDEX_WINDOW;
  localparam logic [15:0] A_DAT = hbi_ctrl_pkg::ADDR_RTC_DATA_WINDOW;
  localparam logic [15:0] A_BHI = hbi_ctrl_pkg::ADDR_PNP_BASE_ADDRESS_HIGH;
  // synchronisers need flushing after reset before pin relations hold
  logic [1:0] up_r;
  always_ff @(posedge clk) begin
    if (!rst_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_pin_mirror: assert property (
    up_r == 2'h3 && core_addr == A_CS1 |-> core_rdata[7:5] == 3'h0 &&
    core_rdata[4:3] == {$past(host_warm_reset_pin, 2), $past(host_power_good, 2)})
    else $error("status pin bits wrong");
  chk_pulse_len: assert property (
    core_wr && core_addr == A_CS1 && core_wdata[1] && !rtc_lock_reset_pulse
    |=> rtc_lock_reset_pulse [*2] ##1 !rtc_lock_reset_pulse)
    else $error("lock reset pulse length wrong");
  chk_hrst_drive: assert property (
    core_wr && core_addr == A_CS2 && core_wdata[0] |=> !host_reset_out_n)
    else $error("host reset not driven");
  chk_poff_gate: assert property (
    up_r == 2'h3 && power_off_to_units |-> $past(power_off_event, 2))
    else $error("power off routed without event");
  chk_valid_cause: assert property (
    $rose(pnp_addr_valid) |-> $past(core_wr && core_addr == A_BHI))
    else $error("valid set without high byte write");
  chk_base_hold: assert property (
    $changed(pnp_base_addr) |-> $past(pnp_first_write))
    else $error("base address changed without capture");
  chk_obe_irq: assert property (kbc_out_empty_irq |-> !kbc_obf)
    else $error("out empty irq with buffer full");
  chk_ibf_irq: assert property (kbc_in_full_irq |-> kbc_ibf)
    else $error("in full irq with buffer empty");
  chk_win_deny: assert property (
    core_wr && core_addr == A_IDX && !rtc_core_sel |-> !rtc_core_wr_index)
    else $error("index write passed while unlocked");
  chk_win_grant: assert property (
    core_wr && core_addr == A_DAT && rtc_core_sel && !core_wait
    |-> rtc_core_wr_data && rtc_core_wdata == core_wdata)
    else $error("data write not passed to rtc");
  chk_wait_cause: assert property (
    core_wait |-> (core_wr || core_rd) && (core_addr == A_IDX || core_addr == A_DAT))
    else $error("stall outside rtc window access");
endmodule
bind host_interface_control_regs hicr_chk hicr_chk_inst (.*);

// ==== hicr_host_model.sv ====
// host bus pins and rtc seen from the far side of the bank
`timescale 1ns/1ps
module hicr_host_model (
  input wire logic clk, // clock
  input wire logic host_channel_ready, // low stalls host
  input wire logic rtc_lock_reset_pulse, // clears lock register
  input wire logic rtc_core_wr_index, // index write
  input wire logic rtc_core_wr_data, // data write
  input wire logic [7:0] rtc_core_wdata, // write data
  output logic [7:0] rtc_index_rdata, // index readback
  output logic [7:0] rtc_data_rdata, // data readback
  output logic rtc_busy, // rtc busy
  output logic host_rtc_req, // host cycle
  output logic host_power_good, // supply pin
  output logic host_warm_reset_pin, // reset pin
  output logic power_off_event // off command
);
  logic [7:0] idx_r;
  logic [7:0] lock_r;
  logic [7:0] mem_r [256];
  initial begin
    {idx_r, lock_r} = 16'h0000;
    {rtc_busy, host_rtc_req, host_warm_reset_pin, power_off_event} = 4'h0;
    host_power_good = 1'b1;
  end
  always @(posedge clk) begin
    if (rtc_core_wr_index) idx_r <= rtc_core_wdata;
    if (rtc_core_wr_data) mem_r[idx_r] <= rtc_core_wdata;
    if (rtc_lock_reset_pulse) lock_r <= 8'h00;
  end
  assign rtc_index_rdata = idx_r;
  assign rtc_data_rdata = mem_r[idx_r];
  // request is held until ready is seen high just before an edge
  task host_cycle(output int stretch);
    stretch = 0;
    @(posedge clk) #1 host_rtc_req = 1'b1;
    repeat (3) @(posedge clk);
    #3;
    while (host_channel_ready !== 1'b1 && stretch < 60) begin
      @(posedge clk) #3;
      stretch++;
    end
    @(posedge clk) #1 host_rtc_req = 1'b0;
  endtask
endmodule

// ==== host_interface_control_regs_bench.sv ====
// directed register tests for the host interface control bank
`timescale 1ns/1ps
module host_interface_control_regs_bench;
  logic clk, rst_n, cold_rst_n, core_wr, core_rd, core_wait, hw_reset_request;
  logic [15:0] core_addr, pnp_base_addr;
  logic [7:0] core_wdata, core_rdata, rtc_core_wdata, rtc_index_rdata, rtc_data_rdata, sv;
  logic host_power_good, host_warm_reset_pin, host_rtc_req, host_channel_ready, rtc_busy;
  logic rtc_lock_reset_pulse, rtc_core_sel, rtc_core_wr_index, rtc_core_wr_data;
  logic rtc_core_rd_data, host_reset_out_n, pnp_first_write, pnp_addr_valid;
  logic power_off_event, power_off_to_units, kbc_obf, kbc_ibf, pm_obf, pm_ibf;
  logic kbc_out_empty_irq, kbc_in_full_irq, pm_out_empty_irq, pm_in_full_irq;
  logic kbd_irq, mouse_irq, pm_irq;
  int num_errors, cmp_count, st, n;
  host_interface_control_regs host_interface_control_regs_inst (.*);
  hicr_host_model host (.*);
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) #1 core_addr = a;
    core_wdata = d;
    core_wr = 1'b1;
    @(posedge clk) #1 core_wr = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) #1 core_addr = a;
    core_rd = 1'b1;
    #2 cmp(core_rdata, e);
    @(posedge clk) #1 core_rd = 1'b0;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task do_rst(input logic cold);
    @(posedge clk) #1 rst_n = 1'b0;
    cold_rst_n = !cold;
    cyc(4);
    {rst_n, cold_rst_n} = 2'h3;
  endtask
  // counts low cycles on the keyboard line after a data-out write
  task pw(output int w);
    wr(hbi_ctrl_pkg::ADDR_KEYBOARD_DATA_OUT, 8'h00);
    w = 0;
    repeat (24) begin
      if (kbd_irq === 1'b0) w++;
      @(posedge clk) #1;
    end
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #60000;
    num_errors++;
    final_report;
  end
  initial begin
    {rst_n, cold_rst_n, core_wr, core_rd, hw_reset_request, pnp_first_write} = 6'h00;
    {kbc_obf, kbc_ibf, pm_obf, pm_ibf, core_addr, core_wdata} = '0;
    cyc(4);
    {rst_n, cold_rst_n} = 2'h3;
    cyc(3);
    rd(16'hf900, 8'h08);
    rd(16'hf902, 8'h00);
    rd(16'hfea0, 8'h00);
    rd(16'hfea2, 8'h07);
    rd(16'hf9f0, 8'h00);
    wr(16'hf904, 8'h11);
    cmp(host.idx_r, 8'h00);
    wr(16'hf900, 8'h01);
    wr(16'hf904, 8'h0e);
    wr(16'hf906, 8'h5a);
    rd(16'hf906, 8'h5a);
    rd(16'hf904, 8'h0e);
    host.host_cycle(st);
    rd(16'hf900, 8'h0d);
    wr(16'hf900, 8'h01);
    rd(16'hf900, 8'h0d);
    wr(16'hf900, 8'h05);
    rd(16'hf900, 8'h09);
    host.lock_r = 8'h3c;
    sv = host.lock_r;
    wr(16'hf900, 8'h03);
    cyc(3);
    cmp(host.lock_r, 8'h00);
    host.lock_r = sv;
    wr(16'hf900, 8'hf9);
    rd(16'hf900, 8'h09);
    wr(16'hf900, 8'h00);
    host.rtc_busy = 1'b1;
    fork
      host.host_cycle(st);
      begin
        cyc(10);
        host.rtc_busy = 1'b0;
      end
    join
    cmp((st > 1) ? 8'h01 : 8'h00, 8'h01);
    rd(16'hf900, 8'h08);
    host.host_power_good = 1'b0;
    cyc(3);
    rd(16'hf900, 8'h00);
    cmp(host_reset_out_n, 8'h00);
    {host.host_power_good, host.host_warm_reset_pin} = 2'h3;
    cyc(3);
    rd(16'hf900, 8'h18);
    host.host_warm_reset_pin = 1'b0;
    wr(16'hf902, 8'h01);
    cmp(host_reset_out_n, 8'h00);
    hw_reset_request = 1'b1;
    wr(16'hf902, 8'h00);
    cmp(host_reset_out_n, 8'h00);
    hw_reset_request = 1'b0;
    #1 cmp(host_reset_out_n, 8'h01);
    wr(16'hf902, 8'h02);
    wr(16'hf908, 8'h34);
    wr(16'hf90a, 8'h12);
    rd(16'hf902, 8'h02);
    @(posedge clk) #1 pnp_first_write = 1'b1;
    @(posedge clk) #1 pnp_first_write = 1'b0;
    cmp(pnp_base_addr[15:8], 8'h12);
    wr(16'hf908, 8'h56);
    cmp(pnp_base_addr[7:0], 8'h34);
    cmp(pnp_addr_valid, 8'h01);
    wr(16'hf902, 8'h02);
    rd(16'hf902, 8'h00);
    cmp(pnp_addr_valid, 8'h00);
    wr(16'hf90a, 8'h12);
    rd(16'hf902, 8'h02);
    host.power_off_event = 1'b1;
    cyc(3);
    cmp(power_off_to_units, 8'h00);
    wr(16'hf902, 8'h0c);
    cmp(power_off_to_units, 8'h01);
    host.power_off_event = 1'b0;
    rd(16'hf902, 8'h0e);
    wr(16'hf902, 8'h02);
    rd(16'hf902, 8'h06);
    wr(16'hf908, 8'hff);
    rd(16'hf908, 8'h56);
    wr(16'hf902, 8'h09);
    do_rst(1'b0);
    rd(16'hf902, 8'h04);
    rd(16'hf90a, 8'h12);
    do_rst(1'b1);
    rd(16'hf902, 8'h00);
    wr(16'hfea2, 8'h05);
    cyc(2);
    cmp({kbd_irq, mouse_irq, pm_irq}, 8'h05);
    wr(16'hfea0, 8'hff);
    rd(16'hfea0, 8'h7f);
    {kbc_obf, kbc_ibf, pm_obf, pm_ibf} = 4'hf;
    wr(16'hfea2, 8'h00);
    cyc(2);
    cmp({kbd_irq, pm_irq, kbc_out_empty_irq, kbc_in_full_irq}, 8'h0d);
    cmp({pm_out_empty_irq, pm_in_full_irq}, 8'h01);
    {kbc_obf, kbc_ibf, pm_obf, pm_ibf} = 4'h0;
    cyc(2);
    cmp({kbd_irq, pm_irq, kbc_out_empty_irq, kbc_in_full_irq}, 8'h02);
    wr(16'hfea2, 8'h40);
    cyc(2);
    cmp(kbd_irq, 8'h01);
    wr(16'hfea0, 8'h01);
    cmp({kbc_out_empty_irq, kbc_in_full_irq}, 8'h00);
    for (int c = 1; c <= 5; c++) begin
      wr(16'hfea2, 8'(c << 3));
      cyc(2);
      pw(n);
      cmp(8'(n), 8'(1 << (c - 1)));
    end
    final_report;
  end
endmodule
